// ### hdl/sio_sync_serial.sv
/*
 * Clocked-synchronous 8-bit serial channel with an AHB-Lite register slave.
 * Assumes one clock; the serial clock and input pins are asynchronous.
 */
// The address map and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module sio_sync_serial
    import sio_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic serialClockPinIn,
    output logic serialClockPinOut,
    output logic serialClockPinOe,
    output logic serialOutputPin,
    input wire logic serialInputPin,
    output logic serialBufferInterrupt
);
    typedef struct packed {
        logic sck1;
        logic sck2;
        logic sck3;
        logic si1;
        logic si2;
        logic startR;
        logic abortR;
        logic [1:0] modeR;
        logic [2:0] clkSelR;
        logic active;
        logic [7:0] bufR;
        logic txPend;
        logic rxPend;
        logic [7:0] shR;
        logic [3:0] cnt;
        logic sckOut;
        logic soR;
        logic discard;
        logic dummy;
        logic irq;
        logic [31:0] rdata;
        logic [ADDR_W-1:0] dAddr;
        logic dWrite;
        logic dValid;
    } state_t;

    state_t s;
    state_t n;
    logic ext;
    logic tick;
    logic fallE;
    logic riseE;
    logic canGo;
    logic run;
    logic ctrlWr;
    logic bufWr;
    logic txMode;
    logic rxMode;

    // ------------------------------------------------------------------
    // Serial clock edges
    // ------------------------------------------------------------------
    assign ext = (s.clkSelR == CLKSEL_EXT);
    assign txMode = (s.modeR == MODE_TX) || (s.modeR == MODE_TXRX);
    assign rxMode = (s.modeR == MODE_RX) || (s.modeR == MODE_TXRX);
    // Falling edge is the leading edge rising is trailing
    assign fallE = ext ? (s.sck3 && !s.sck2) : (tick && s.sckOut);
    assign riseE = ext ? (!s.sck3 && s.sck2) : (tick && !s.sckOut);
    // Auto wait (internal clock): next byte needs tx data in tx modes and a read rx buffer in rx modes
    assign canGo = (!txMode || s.txPend) && (!rxMode || !s.rxPend);
    assign run = s.active && !ext && ((s.cnt != 4'h0) || canGo);
    assign ctrlWr = s.dValid && s.dWrite && (s.dAddr == SERIAL_CONTROL_REGISTER_ONE_OFS);
    assign bufWr = s.dValid && s.dWrite && (s.dAddr == SERIAL_DATA_BUFFER_OFS);

    sio_clk_div u_div (
        .clk(clk),
        .rst(rst),
        .run(run),
        .sel(s.clkSelR),
        .tick(tick)
    );

    always_comb begin
        n = s;
        n.irq = 1'b0;
        n.sck1 = serialClockPinIn;
        n.sck2 = s.sck1;
        n.sck3 = s.sck2;
        n.si1 = serialInputPin;
        n.si2 = s.si1;
        // ------------------------------------------------------------------
        // Bus address phase and read side effects
        // ------------------------------------------------------------------
        n.dValid = 1'b0;
        if (hsel && hready && htrans[1]) begin
            n.dValid = 1'b1;
            n.dWrite = hwrite;
            n.dAddr = haddr[ADDR_W-1:0];
            if (!hwrite) begin
                n.rdata = 32'h0000_0000;
                case (haddr[ADDR_W-1:0])
                    SERIAL_CONTROL_REGISTER_ONE_OFS: begin
                        n.rdata[START_BIT] = s.startR;
                        n.rdata[ABORT_BIT] = s.abortR;
                        n.rdata[MODE_LSB+:2] = s.modeR;
                        n.rdata[CLKSEL_LSB+:3] = s.clkSelR;
                    end
                    SERIAL_DATA_BUFFER_OFS: begin
                        n.rdata[7:0] = s.bufR;
                        n.rxPend = 1'b0;
                    end
                    SERIAL_STATUS_REGISTER_OFS: begin
                        n.rdata[ACTIVE_BIT] = s.active;
                        n.rdata[SHIFT_BIT] = (s.cnt != 4'h0);
                    end
                    default: begin
                        n.rdata = 32'h0000_0000;
                    end
                endcase
            end
        end
        // ------------------------------------------------------------------
        // Shifter
        // ------------------------------------------------------------------
        if (!ext && tick) begin
            n.sckOut = !s.sckOut;
        end
        if (s.active && fallE) begin
            if (s.cnt == 4'h0) begin
                if (txMode) begin
                    if (s.txPend) begin
                        n.shR = s.bufR;
                        n.txPend = 1'b0;
                        n.soR = s.bufR[0];
                        n.irq = (s.modeR == MODE_TX);
                    end else begin
                        n.dummy = 1'b1;
                        n.soR = s.shR[0];
                    end
                end
                n.discard = rxMode && s.rxPend;
                n.cnt = 4'h1;
            end else if (txMode) begin
                n.soR = s.shR[0];
            end
        end
        if (s.active && riseE && (s.cnt != 4'h0)) begin
            n.shR = {s.si2, s.shR[7:1]};
            if (s.cnt == 4'(BITS_PER_BYTE)) begin
                n.cnt = 4'h0;
                if (rxMode && !s.discard) begin
                    n.bufR = {s.si2, s.shR[7:1]};
                    n.rxPend = 1'b1;
                    n.irq = 1'b1;
                end
                // Stop only on byte boundary
                if (s.dummy || (!s.startR && (!txMode || !s.txPend || rxMode))) begin
                    n.active = 1'b0;
                end
                n.dummy = 1'b0;
                n.discard = 1'b0;
            end else begin
                n.cnt = s.cnt + 4'h1;
            end
        end
        // Start cleared while idle between bytes: nothing in flight, end now
        if (s.active && (s.cnt == 4'h0) && !fallE && !s.startR && (!txMode || !s.txPend || rxMode)) begin
            n.active = 1'b0;
        end
        // ------------------------------------------------------------------
        // Bus data phase writes
        // ------------------------------------------------------------------
        if (bufWr) begin
            n.bufR = hwdata[7:0];
            n.txPend = txMode;
        end
        if (ctrlWr) begin
            n.startR = hwdata[START_BIT];
            n.abortR = hwdata[ABORT_BIT];
            n.modeR = hwdata[MODE_LSB+:2];
            n.clkSelR = hwdata[CLKSEL_LSB+:3];
            if (hwdata[MODE_LSB+:2] != s.modeR) begin
                n.txPend = 1'b0;
                n.rxPend = 1'b0;
            end
            if (hwdata[ABORT_BIT]) begin
                n.active = 1'b0;
                n.cnt = 4'h0;
                n.dummy = 1'b0;
                n.discard = 1'b0;
            end else if (hwdata[START_BIT] && !s.active && (hwdata[MODE_LSB+:2] != MODE_RSVD)) begin
                n.active = 1'b1;
                n.cnt = 4'h0;
            end
        end else if (s.abortR && !s.active) begin
            n.abortR = 1'b0;
        end
        if (!n.active && !ext) begin
            n.sckOut = SCK_IDLE;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= '0;
            s.sckOut <= SCK_IDLE;
            s.sck1 <= SCK_IDLE;
            s.sck2 <= SCK_IDLE;
            s.sck3 <= SCK_IDLE;
            s.soR <= SO_IDLE;
            s.modeR <= MODE_RST;
            s.clkSelR <= CLKSEL_RST;
        end else begin
            s <= n;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s.rdata;
    assign serialClockPinOut = s.sckOut;
    assign serialClockPinOe = !ext;
    assign serialOutputPin = s.soR;
    assign serialBufferInterrupt = s.irq;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_abortStop;
        @(posedge clk) disable iff (rst)
        (ctrlWr && hwdata[ABORT_BIT]) |=> (!s.active && (s.cnt == 4'h0));
    endproperty
    a_abortStop: assert property (p_abortStop) else $error("abort did not stop transfer");

    property p_abortClear;
        @(posedge clk) disable iff (rst)
        (s.abortR && !s.active && !ctrlWr) |=> !s.abortR;
    endproperty
    a_abortClear: assert property (p_abortClear) else $error("abort bit not self cleared");

    property p_soHold;
        @(posedge clk) disable iff (rst)
        !(s.active && fallE) |=> $stable(serialOutputPin);
    endproperty
    a_soHold: assert property (p_soHold) else $error("output pin moved off falling edge");

    property p_txWait;
        @(posedge clk) disable iff (rst)
        (!ext && s.active && (s.modeR == MODE_TX) && (s.cnt == 4'h0) && !s.txPend && !bufWr) [*2]
        |-> !tick && serialClockPinOut;
    endproperty
    a_txWait: assert property (p_txWait) else $error("clock ran without transmit data");

    property p_rxWait;
        @(posedge clk) disable iff (rst)
        (!ext && s.active && rxMode && (s.cnt == 4'h0) && s.rxPend) [*2] |-> !tick;
    endproperty
    a_rxWait: assert property (p_rxWait) else $error("clock ran with unread receive data");

    property p_txLoad;
        @(posedge clk) disable iff (rst)
        (s.active && fallE && (s.cnt == 4'h0) && (s.modeR == MODE_TX) && s.txPend && !bufWr)
        |=> (!s.txPend && serialBufferInterrupt && (serialOutputPin == $past(s.bufR[0])));
    endproperty
    a_txLoad: assert property (p_txLoad) else $error("transmit load did not empty buffer");

    property p_rxDone;
        @(posedge clk) disable iff (rst)
        (s.active && riseE && (s.cnt == 4'h8) && rxMode && !s.discard && !bufWr && !ctrlWr)
        |=> (s.rxPend && serialBufferInterrupt && (s.bufR[7] == $past(s.si2)));
    endproperty
    a_rxDone: assert property (p_rxDone) else $error("received byte not delivered");

    property p_extNoDrive;
        @(posedge clk) disable iff (rst)
        (s.clkSelR == CLKSEL_EXT) |-> !serialClockPinOe && !run;
    endproperty
    a_extNoDrive: assert property (p_extNoDrive) else $error("pin clock driven in external mode");

    property p_cntRange;
        @(posedge clk) disable iff (rst)
        (s.cnt <= 4'h8) && (s.active || (s.cnt == 4'h0) || ctrlWr);
    endproperty
    a_cntRange: assert property (p_cntRange) else $error("bit counter out of range");

    property p_idleStop;
        @(posedge clk) disable iff (rst)
        (s.active && (s.cnt == 4'h0) && !fallE && !s.startR && rxMode) |=> !s.active;
    endproperty
    a_idleStop: assert property (p_idleStop) else $error("start clear did not end idle transfer");
endmodule : sio_sync_serial
`default_nettype wire

// ### hdl/sio_pkg.sv
/*
 * Constants for the clocked-synchronous 8-bit serial block: register offsets,
 * field positions, reset values, transfer modes and clock divider settings.
 * Assumes a 32-bit AHB-Lite register bus with one word per register.
 */
package sio_pkg;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] SERIAL_CONTROL_REGISTER_ONE_OFS = 8'h00;
    localparam logic [7:0] SERIAL_DATA_BUFFER_OFS = 8'h04;
    localparam logic [7:0] SERIAL_STATUS_REGISTER_OFS = 8'h08;
    // ------------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------------
    localparam int START_BIT = 7;
    localparam int ABORT_BIT = 6;
    localparam int MODE_LSB = 4;
    localparam int CLKSEL_LSB = 0;
    // ------------------------------------------------------------------
    // Status fields
    // ------------------------------------------------------------------
    localparam int ACTIVE_BIT = 3;
    localparam int SHIFT_BIT = 2;
    // ------------------------------------------------------------------
    // Modes and clock select
    // ------------------------------------------------------------------
    localparam logic [1:0] MODE_TX = 2'h0;
    localparam logic [1:0] MODE_RSVD = 2'h1;
    localparam logic [1:0] MODE_TXRX = 2'h2;
    localparam logic [1:0] MODE_RX = 2'h3;
    localparam logic [2:0] CLKSEL_EXT = 3'h7;
    localparam logic [2:0] CLKSEL_RST = 3'h0;
    localparam logic [1:0] MODE_RST = 2'h0;
    localparam int BITS_PER_BYTE = 8;
    localparam int DIV_W = 10;
    localparam int DIV_EXP_BASE = 3;
    localparam logic SCK_IDLE = 1'b1;
    localparam logic SO_IDLE = 1'b1;
endpackage : sio_pkg

// ### hdl/sio_clk_div.sv
/*
 * Serial clock divider: one-cycle tick each half period of the internal
 * serial clock while run is high. Assumes the same clock as the user.
 */
`timescale 1ns/10ps
`default_nettype none
module sio_clk_div
    import sio_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    input wire logic [2:0] sel,
    output logic tick
);
    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic tick;
    } div_t;

    div_t s;
    div_t n;
    logic [DIV_W-1:0] lim;

    always_comb begin
        lim = DIV_W'((32'd1 << (32'(sel) + DIV_EXP_BASE)) - 32'd1);
        n = s;
        n.tick = 1'b0;
        if (!run) begin
            n.cnt = '0;
        end else if (s.cnt == lim) begin
            n.cnt = '0;
            n.tick = 1'b1;
        end else begin
            n.cnt = s.cnt + DIV_W'(1);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign tick = s.tick;
endmodule : sio_clk_div
`default_nettype wire

// ### tb/sio_partner.sv
/*
 * Far-side serial peer: samples the data-out line on rising serial clock,
 * drives the data-in line on falling serial clock, and can make the clock.
 * Assumes the bench resolves the shared clock wire and feeds it back here.
 */
`timescale 1ns/10ps
`default_nettype none
module sio_partner (
    input wire logic clk,
    input wire logic sck,
    input wire logic so,
    output logic si,
    output logic extClk
);
    logic [7:0] rxShift;
    logic [7:0] txShift;
    int bitCnt;
    initial begin
        rxShift = 8'h00;
        txShift = 8'h00;
        si = 1'b1;
        extClk = 1'b1;
        bitCnt = 0;
    end
    // ------------------------------------------------------------------
    // Capture and drive
    // ------------------------------------------------------------------
    always @(posedge sck) begin
        rxShift <= {so, rxShift[7:1]};
        bitCnt <= bitCnt + 1;
    end
    // Used-up bits refill with inverted data so a stale line never matches
    always @(negedge sck) begin
        si <= txShift[0];
        txShift <= {~txShift[0], txShift[7:1]};
    end
    task automatic load(input logic [7:0] b);
        txShift = b;
    endtask : load
    // Clock stands high outside frames
    task automatic extByte(input int half);
        repeat (8) begin
            repeat (half) @(posedge clk);
            extClk <= 1'b0;
            repeat (half) @(posedge clk);
            extClk <= 1'b1;
        end
    endtask : extByte
endmodule : sio_partner
`default_nettype wire

// ### tb/tb_top.sv
/*
 * Self-checking bench for the serial channel: AHB-Lite master tasks,
 * transmit, receive, duplex, abort, reserved mode and external clock runs.
 * Assumes the partner model on the serial pins and a 200 MHz clock.
 */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import sio_pkg::*;
    logic clk, rst, hsel, hwrite, hreadyout, hresp, sckOut, sckOe, sckWire, so, si, irq, extClk;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] b0, b1, b2;
    int fails, compares, irqCnt, cycles, bitBase;
    assign sckWire = sckOe ? sckOut : extClk;
    sio_sync_serial u_dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .serialClockPinIn(sckWire), .serialClockPinOut(sckOut),
        .serialClockPinOe(sckOe), .serialOutputPin(so), .serialInputPin(si), .serialBufferInterrupt(irq));
    sio_partner u_partner (.clk(clk), .sck(sckWire), .so(so), .si(si), .extClk(extClk));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (irq === 1'b1) irqCnt <= irqCnt + 1;
        if (cycles == 40000) begin
            fails = fails + 1;
            give_verdict();
        end
    end
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        compares = compares + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : check
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {24'h000000, a};
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask : bus
    function automatic logic [31:0] ctl(input logic st, input logic ab, input logic [1:0] m,
            input logic [2:0] s);
        return {24'h000000, st, ab, m, 1'b0, s};
    endfunction : ctl
    task automatic waitIrq(input int n);
        int t;
        t = 0;
        while (irqCnt < n && t < 3000) begin
            @(posedge clk);
            t++;
        end
        check(irqCnt, n, "interrupt count");
    endtask : waitIrq
    task automatic waitBits(input int n);
        int t;
        t = 0;
        while (u_partner.bitCnt < n && t < 3000) begin
            @(posedge clk);
            t++;
        end
        check(u_partner.bitCnt, n, "serial clock bits");
    endtask : waitBits
    task automatic holdHigh(input int n);
        int low;
        low = 0;
        repeat (n) begin
            @(posedge clk);
            if (sckOut !== 1'b1) low++;
        end
        check(low, 0, "clock held in wait");
    endtask : holdHigh
    task automatic waitIdle();
        int t;
        t = 0;
        bus(1'b0, SERIAL_STATUS_REGISTER_OFS, 32'h0);
        while (rd[ACTIVE_BIT] !== 1'b0 && t < 100) begin
            bus(1'b0, SERIAL_STATUS_REGISTER_OFS, 32'h0);
            t++;
        end
        check(rd[ACTIVE_BIT], 1'b0, "active flag cleared");
    endtask : waitIdle
    task automatic give_verdict();
        $display("Counts: %0d compares, %0d fails", compares, fails);
        if (fails == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : give_verdict
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        rst = 1'b1;
        {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
        {fails, compares, irqCnt, cycles} = '0;
        void'($urandom(32'h9f9a));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        hsize <= 3'h2;
        @(posedge clk);
        check({sckOut, sckOe, so, irq, hresp}, 5'h1C, "idle pins");
        bus(1'b0, SERIAL_STATUS_REGISTER_OFS, 32'h0);
        check(rd, 32'h0, "status after reset");
        bus(1'b0, 8'hF0, 32'h0);
        check(rd, 32'h0, "unmapped read");
        $display("test reset done");
        b0 = 8'($urandom);
        b1 = 8'h80;
        bitBase = u_partner.bitCnt;
        bus(1'b1, SERIAL_DATA_BUFFER_OFS, {24'h0, b0});
        bus(1'b1, SERIAL_CONTROL_REGISTER_ONE_OFS, ctl(1'b1, 1'b0, MODE_TX, 3'h0));
        waitIrq(1);
        waitBits(bitBase + 8);
        check(u_partner.rxShift, b0, "tx byte");
        holdHigh(40);
        bus(1'b0, SERIAL_STATUS_REGISTER_OFS, 32'h0);
        check(rd[ACTIVE_BIT], 1'b1, "active while waiting");
        bus(1'b1, SERIAL_DATA_BUFFER_OFS, {24'h0, b1});
        waitIrq(2);
        bus(1'b1, SERIAL_CONTROL_REGISTER_ONE_OFS, ctl(1'b0, 1'b0, MODE_TX, 3'h0));
        waitIdle();
        check(u_partner.rxShift, b1, "tx byte after stop");
        $display("test transmit done");
        b2 = 8'($urandom);
        u_partner.load(b2);
        bus(1'b1, SERIAL_CONTROL_REGISTER_ONE_OFS, ctl(1'b1, 1'b0, MODE_RX, 3'h0));
        waitIrq(3);
        holdHigh(40);
        bus(1'b1, SERIAL_CONTROL_REGISTER_ONE_OFS, ctl(1'b0, 1'b0, MODE_RX, 3'h0));
        bus(1'b0, SERIAL_DATA_BUFFER_OFS, 32'h0);
        check(rd, {24'h0, b2}, "rx byte");
        waitIdle();
        $display("test receive done");
        b0 = 8'($urandom);
        b1 = 8'($urandom);
        u_partner.load(b1);
        bus(1'b1, SERIAL_CONTROL_REGISTER_ONE_OFS, ctl(1'b0, 1'b0, MODE_TXRX, 3'h0));
        bus(1'b1, SERIAL_DATA_BUFFER_OFS, {24'h0, b0});
        bus(1'b1, SERIAL_CONTROL_REGISTER_ONE_OFS, ctl(1'b1, 1'b0, MODE_TXRX, 3'h0));
        waitIrq(4);
        bus(1'b0, SERIAL_DATA_BUFFER_OFS, 32'h0);
        check(rd, {24'h0, b1}, "duplex rx byte");
        check(u_partner.rxShift, b0, "duplex tx byte");
        holdHigh(40);
        bus(1'b1, SERIAL_CONTROL_REGISTER_ONE_OFS, ctl(1'b0, 1'b1, MODE_TXRX, 3'h0));
        bus(1'b0, SERIAL_STATUS_REGISTER_OFS, 32'h0);
        check(rd[ACTIVE_BIT], 1'b0, "abort clears active");
        bus(1'b0, SERIAL_CONTROL_REGISTER_ONE_OFS, 32'h0);
        check(rd[ABORT_BIT], 1'b0, "abort bit self cleared");
        $display("test duplex abort done");
        bus(1'b1, SERIAL_CONTROL_REGISTER_ONE_OFS, ctl(1'b1, 1'b0, MODE_RSVD, 3'h0));
        bus(1'b0, SERIAL_STATUS_REGISTER_OFS, 32'h0);
        check(rd[ACTIVE_BIT], 1'b0, "reserved mode idle");
        $display("test reserved done");
        b2 = 8'($urandom);
        u_partner.load(b2);
        bus(1'b1, SERIAL_CONTROL_REGISTER_ONE_OFS, ctl(1'b1, 1'b0, MODE_RX, CLKSEL_EXT));
        @(posedge clk);
        check(sckOe, 1'b0, "clock pin released");
        u_partner.extByte(10);
        waitIrq(5);
        u_partner.load(~b2);
        u_partner.extByte(10);
        repeat (4) @(posedge clk);
        check(irqCnt, 5, "byte discarded while unread");
        bus(1'b1, SERIAL_CONTROL_REGISTER_ONE_OFS, ctl(1'b0, 1'b0, MODE_RX, CLKSEL_EXT));
        bus(1'b0, SERIAL_DATA_BUFFER_OFS, 32'h0);
        check(rd, {24'h0, b2}, "ext rx byte");
        waitIdle();
        $display("test external done");
        b0 = 8'($urandom);
        b1 = 8'($urandom);
        bus(1'b1, SERIAL_CONTROL_REGISTER_ONE_OFS, ctl(1'b0, 1'b0, MODE_TX, CLKSEL_EXT));
        bus(1'b1, SERIAL_DATA_BUFFER_OFS, {24'h0, b0});
        bus(1'b1, SERIAL_CONTROL_REGISTER_ONE_OFS, ctl(1'b1, 1'b0, MODE_TX, CLKSEL_EXT));
        u_partner.extByte(10);
        repeat (4) @(posedge clk);
        check(u_partner.rxShift, b0, "ext tx byte");
        bus(1'b1, SERIAL_DATA_BUFFER_OFS, {24'h0, b1});
        u_partner.extByte(10);
        repeat (4) @(posedge clk);
        check(u_partner.rxShift, b1, "ext tx next byte");
        u_partner.extByte(10);
        waitIdle();
        check(irqCnt, 7, "no load for dummy byte");
        $display("test external transmit done");
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
